// ===== hw/pbc_pkg.sv
package pbc_pkg;
	// Register addresses on the host register port
	localparam logic [8:0] PBC_ADDR_CTRL = 9'h03b;
	localparam logic [8:0] PBC_ADDR_DSCH = 9'h1c7;
	// Reset values
	localparam logic [7:0] PBC_CTRL_RST = 8'h24;
	localparam logic [7:0] PBC_DSCH_RST = 8'h01;
	// Field positions
	localparam int PBC_STATE_LSB = 0;
	localparam int PBC_EXIT_LSB = 3;
	localparam int PBC_VSEL_LSB = 6;
	localparam int PBC_DSCH_BIT = 0;
	// State field encodings
	localparam logic [2:0] PBC_ST_OFF = 3'h4;
	localparam logic [2:0] PBC_ST_ON = 3'h7;
	// Voltage select encodings
	localparam logic [1:0] PBC_V_4V2 = 2'h0;
	localparam logic [1:0] PBC_V_5V0 = 2'h2;
	// Soft start blanking of short-circuit detection
	localparam int PBC_SOFT_START_US = 4000;
	localparam int PBC_CLK_MHZ = 100;
	localparam int PBC_SOFT_START_CYC = PBC_SOFT_START_US * PBC_CLK_MHZ;

	typedef enum logic [1:0] {
		PBC_OFF,
		PBC_SOFT,
		PBC_RUN,
		PBC_TRIPPED
	} pbc_reg_state_e;

	typedef struct packed {
		logic ov;
		logic uv;
		logic oc;
		logic sc;
	} pbc_comp_s;

	typedef struct packed {
		logic wr;
		logic [8:0] addr;
		logic [7:0] wdata;
	} pbc_wr_s;
endpackage : pbc_pkg

// ===== hw/pbc_sync.sv
`timescale 1ns/1ps
module pbc_sync
	import pbc_pkg::*;
#(
	parameter int W = 5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			q_ff <= '0;
		end else begin
			meta_ff <= d;
			q_ff <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule : pbc_sync

// ===== hw/pbc_top.sv
`timescale 1ns/1ps
module pbc_top
	import pbc_pkg::*;
#(
	parameter int SOFT_START_CYC = PBC_SOFT_START_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic reg_wr,
	input wire logic [8:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Analog comparators and standby exit pin (asynchronous)
	input wire logic cmp_ov,
	input wire logic cmp_uv,
	input wire logic cmp_oc,
	input wire logic cmp_sc,
	input wire logic standby_exit_pin,
	// Regulator controls
	output logic pa_boost_regulator_en,
	output logic power_switch_en,
	output logic isolation_switch_en,
	output logic uv_comp_en,
	output logic vsel_5v0,
	output logic discharge_en,
	output logic pa_boost_fault
);
	logic [7:0] ctrl_ff;
	logic [7:0] nxt_ctrl;
	logic [7:0] dsch_ff;
	logic [7:0] nxt_dsch;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	pbc_reg_state_e st_ff;
	pbc_reg_state_e nxt_st;
	logic [22:0] ss_cnt_ff;
	logic [22:0] nxt_ss_cnt;
	logic ov_lat_ff;
	logic sc_lat_ff;
	logic nxt_ov_lat;
	logic nxt_sc_lat;
	logic exit_d_ff;
	logic en_ff;
	logic pwr_ff;
	logic iso_ff;
	logic uvc_ff;
	logic v5_ff;
	logic dsen_ff;
	logic fault_ff;
	logic [4:0] sync_q;
	pbc_comp_s cmp;
	pbc_wr_s wr;
	logic exit_s;

	pbc_sync #(.W(5)) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({cmp_ov, cmp_uv, cmp_oc, cmp_sc, standby_exit_pin}),
		.q(sync_q)
	);

	assign cmp = pbc_comp_s'(sync_q[4:1]);
	assign exit_s = sync_q[0];
	assign wr = '{wr: reg_wr, addr: reg_addr, wdata: reg_wdata};

	function automatic logic is_valid_state(input logic [2:0] v);
		return (v == PBC_ST_OFF) || (v == PBC_ST_ON);
	endfunction : is_valid_state

	// Decode
	wire wr_ctrl = wr.wr && (wr.addr == PBC_ADDR_CTRL);
	wire wr_dsch = wr.wr && (wr.addr == PBC_ADDR_DSCH);
	wire [2:0] state_fld = ctrl_ff[PBC_STATE_LSB +: 3];
	wire [2:0] exit_fld = ctrl_ff[PBC_EXIT_LSB +: 3];
	wire exit_rise = exit_s && !exit_d_ff;
	wire exit_copy = exit_rise && is_valid_state(exit_fld);
	wire want_on = (state_fld == PBC_ST_ON);
	wire [22:0] ss_last = 23'(SOFT_START_CYC - 1);
	wire ss_done = (ss_cnt_ff == ss_last);
	wire running = (st_ff == PBC_SOFT) || (st_ff == PBC_RUN);
	wire sc_hit = (st_ff == PBC_RUN) && cmp.sc;
	wire ov_hit = running && cmp.ov;
	wire turn_on = want_on && (st_ff == PBC_OFF);

	// Control register: writes take precedence over a standby exit copy
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (exit_copy) begin
			nxt_ctrl[PBC_STATE_LSB +: 3] = exit_fld;
		end
		if (wr_ctrl) begin
			nxt_ctrl = wr.wdata;
		end
		nxt_dsch = dsch_ff;
		if (wr_dsch) begin
			nxt_dsch = {7'h00, wr.wdata[PBC_DSCH_BIT]};
		end
	end

	assign nxt_rdata = (wr.addr == PBC_ADDR_CTRL) ? ctrl_ff :
		(wr.addr == PBC_ADDR_DSCH) ? dsch_ff : 8'h00;

	// Regulator sequencing
	always_comb begin
		nxt_st = st_ff;
		nxt_ss_cnt = ss_cnt_ff;
		case (st_ff)
			PBC_OFF: begin
				nxt_ss_cnt = '0;
				if (turn_on) begin
					nxt_st = PBC_SOFT;
				end
			end
			PBC_SOFT: begin
				nxt_ss_cnt = ss_cnt_ff + 23'h000001;
				if (!want_on) begin
					nxt_st = PBC_OFF;
				end else if (ov_hit) begin
					nxt_st = PBC_TRIPPED;
				end else if (ss_done) begin
					nxt_st = PBC_RUN;
				end
			end
			PBC_RUN: begin
				if (!want_on) begin
					nxt_st = PBC_OFF;
				end else if (ov_hit || sc_hit) begin
					nxt_st = PBC_TRIPPED;
				end
			end
			PBC_TRIPPED: begin
				// No automatic restart: only an off then on sequence revives it
				if (!want_on) begin
					nxt_st = PBC_OFF;
				end
			end
			default: nxt_st = PBC_OFF;
		endcase
	end

	// Latched faults clear only on the turn-on transition; a trip wins
	assign nxt_ov_lat = ov_hit || (ov_lat_ff && !turn_on);
	assign nxt_sc_lat = sc_hit || (sc_lat_ff && !turn_on);

	// Fault: soft start keeps it set, then live UV/OC plus latches
	// Turn-on raises the flag in the same cycle as the enable, so it never lags
	wire live_fault = turn_on || (st_ff == PBC_SOFT) || (running && (cmp.uv || cmp.oc));
	wire nxt_fault = live_fault || nxt_ov_lat || nxt_sc_lat;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= PBC_CTRL_RST;
			dsch_ff <= PBC_DSCH_RST;
			rdata_ff <= 8'h00;
			st_ff <= PBC_OFF;
			ss_cnt_ff <= '0;
			ov_lat_ff <= 1'b0;
			sc_lat_ff <= 1'b0;
			exit_d_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			dsch_ff <= nxt_dsch;
			rdata_ff <= nxt_rdata;
			st_ff <= nxt_st;
			ss_cnt_ff <= nxt_ss_cnt;
			ov_lat_ff <= nxt_ov_lat;
			sc_lat_ff <= nxt_sc_lat;
			exit_d_ff <= exit_s;
		end
	end

	wire nxt_en = (nxt_st == PBC_SOFT) || (nxt_st == PBC_RUN);
	// Over-current blanks the power switch cycle by cycle
	wire nxt_pwr = nxt_en && !cmp.oc;
	wire nxt_v5 = (nxt_ctrl[PBC_VSEL_LSB +: 2] == PBC_V_5V0);
	wire nxt_dsen = !nxt_en && !nxt_dsch[PBC_DSCH_BIT];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			en_ff <= 1'b0;
			pwr_ff <= 1'b0;
			iso_ff <= 1'b0;
			uvc_ff <= 1'b0;
			v5_ff <= 1'b0;
			dsen_ff <= 1'b0;
			fault_ff <= 1'b0;
		end else begin
			en_ff <= nxt_en;
			pwr_ff <= nxt_pwr;
			iso_ff <= nxt_en;
			uvc_ff <= nxt_en;
			v5_ff <= nxt_v5;
			dsen_ff <= nxt_dsen;
			fault_ff <= nxt_fault;
		end
	end

	assign reg_rdata = rdata_ff;
	assign pa_boost_regulator_en = en_ff;
	assign power_switch_en = pwr_ff;
	assign isolation_switch_en = iso_ff;
	assign uv_comp_en = uvc_ff;
	assign vsel_5v0 = v5_ff;
	assign discharge_en = dsen_ff;
	assign pa_boost_fault = fault_ff;

	chk_ov_shutdown: assert property (@(posedge clk) disable iff (!rst_n)
		ov_hit |=> !pa_boost_regulator_en && pa_boost_fault)
		else $error("over-voltage did not shut down");

	chk_ov_no_restart: assert property (@(posedge clk) disable iff (!rst_n)
		(st_ff == PBC_TRIPPED) && want_on |=> !pa_boost_regulator_en && pa_boost_fault)
		else $error("restart after over-voltage");

	chk_state_off: assert property (@(posedge clk) disable iff (!rst_n)
		!want_on |=> !pa_boost_regulator_en)
		else $error("regulator on while state not on");

	sequence s_exit_edge;
		exit_s && !exit_d_ff && (exit_fld == PBC_ST_ON) && !wr_ctrl;
	endsequence

	chk_exit_copy: assert property (@(posedge clk) disable iff (!rst_n)
		s_exit_edge |=> (ctrl_ff[2:0] == PBC_ST_ON))
		else $error("standby exit copy missing");

	chk_vsel_map: assert property (@(posedge clk) disable iff (!rst_n)
		vsel_5v0 == (ctrl_ff[PBC_VSEL_LSB +: 2] == PBC_V_5V0))
		else $error("voltage select wrong");

	chk_ctrl_write: assert property (@(posedge clk) disable iff (!rst_n)
		wr_ctrl |=> ##1 (reg_rdata == $past(reg_wdata, 2) || $past(reg_addr) != PBC_ADDR_CTRL))
		else $error("control write not stored");

	chk_dsch_gate: assert property (@(posedge clk) disable iff (!rst_n)
		discharge_en == (!pa_boost_regulator_en && !dsch_ff[PBC_DSCH_BIT]))
		else $error("discharge on while disabled");

	sequence s_turn_on;
		turn_on ##1 (st_ff == PBC_SOFT);
	endsequence

	chk_turnon_fault: assert property (@(posedge clk) disable iff (!rst_n)
		s_turn_on |=> pa_boost_fault && uv_comp_en)
		else $error("turn-on fault not set");

	chk_oc_switch: assert property (@(posedge clk) disable iff (!rst_n)
		cmp.oc |=> !power_switch_en && (pa_boost_fault || !pa_boost_regulator_en))
		else $error("over-current not handled");

	chk_sc_masked: assert property (@(posedge clk) disable iff (!rst_n)
		(st_ff == PBC_SOFT) && cmp.sc && !cmp.ov && want_on && !ss_done |=> st_ff == PBC_SOFT)
		else $error("short circuit not masked in soft start");

	chk_fault_or: assert property (@(posedge clk) disable iff (!rst_n)
		(ov_lat_ff || sc_lat_ff) |-> pa_boost_fault)
		else $error("latched fault not shown");
endmodule : pbc_top

// ===== bench/pbc_host.sv
`timescale 1ns/1ps
module pbc_host
	import pbc_pkg::*;
(
	// Clock
	input wire logic clk,
	// Register port
	input wire logic [7:0] reg_rdata,
	output logic reg_wr,
	output logic [8:0] reg_addr,
	output logic [7:0] reg_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_addr = 9'h000;
		reg_wdata = 8'h00;
	end
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [8:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		@(posedge clk);
		#1 d = reg_rdata;
	endtask : rd
	// Power-up setup, discharge disabled
	task automatic init();
		wr(PBC_ADDR_CTRL, PBC_CTRL_RST);
		wr(PBC_ADDR_DSCH, 8'h01);
	endtask : init
endmodule : pbc_host

// ===== bench/test_pa_boost_control_and_fault.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
	$display("[FAIL] %s exp %h got %h", n, e, a); end end
module test_pa_boost_control_and_fault
	import pbc_pkg::*;
;
	logic clk, rst_n, ov, uv, oc, sc, pin, reg_wr, en, psw, iso, uvc, v5, dsch, flt;
	logic [8:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, v;
	int miscompares, tests_run, cycles;
	pbc_top #(.SOFT_START_CYC(20)) dut_u (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cmp_ov(ov),
		.cmp_uv(uv), .cmp_oc(oc), .cmp_sc(sc), .standby_exit_pin(pin),
		.pa_boost_regulator_en(en), .power_switch_en(psw), .isolation_switch_en(iso),
		.uv_comp_en(uvc), .vsel_5v0(v5), .discharge_en(dsch), .pa_boost_fault(flt));
	pbc_host host_u (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));
	always #5 clk = ~clk;
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic outs(input logic [4:0] e);
		`CHK("en,psw,iso,uvc,fault", e, {en, psw, iso, uvc, flt})
	endtask : outs
	task automatic ctl(input logic [7:0] d);
		host_u.wr(PBC_ADDR_CTRL, d);
		cyc(3);
	endtask : ctl
	// Comparator and pin levels {ov, uv, oc, sc, pin}, changed on a rising edge
	task automatic pins(input logic [4:0] p);
		@(posedge clk);
		{ov, uv, oc, sc, pin} <= p;
	endtask : pins
	task automatic t_reset();
		outs(5'h00);
		host_u.rd(PBC_ADDR_CTRL, v);
		`CHK("ctrl", PBC_CTRL_RST, v)
		host_u.rd(PBC_ADDR_DSCH, v);
		`CHK("dsch", PBC_DSCH_RST, v)
		host_u.rd(9'h0ff, v);
		`CHK("unmapped", 8'h00, v)
		$display("t_reset done");
	endtask : t_reset
	task automatic t_regs();
		host_u.wr(PBC_ADDR_CTRL, 8'ha7);
		cyc(2);
		outs(5'h1f);
		`CHK("vsel", 1'b1, v5)
		host_u.rd(PBC_ADDR_CTRL, v);
		`CHK("ctrl", 8'ha7, v)
		cyc(30);
		outs(5'h1e);
		host_u.wr(PBC_ADDR_DSCH, 8'hfe);
		host_u.rd(PBC_ADDR_DSCH, v);
		`CHK("dsch", 8'h00, v)
		`CHK("dsch_en", 1'b0, dsch)
		ctl(8'h24);
		outs(5'h00);
		`CHK("vsel", 1'b0, v5)
		`CHK("dsch_en", 1'b1, dsch)
		host_u.wr(PBC_ADDR_DSCH, 8'h01);
		cyc(2);
		`CHK("dsch_en", 1'b0, dsch)
		for (int s = 0; s < 7; s++) begin
			ctl(8'h27);
			`CHK("en on", 1'b1, en)
			ctl({5'h04, s[2:0]});
			`CHK("en", 1'b0, en)
		end
		$display("t_regs done");
	endtask : t_regs
	task automatic t_faults();
		ctl(8'h27);
		cyc(30);
		pins(5'h04);
		cyc(4);
		outs(5'h17);
		pins(5'h00);
		cyc(4);
		pins(5'h08);
		cyc(4);
		outs(5'h1f);
		pins(5'h00);
		cyc(4);
		outs(5'h1e);
		pins(5'h10);
		cyc(4);
		outs(5'h01);
		pins(5'h00);
		cyc(10);
		outs(5'h01);
		ctl(8'h24);
		host_u.wr(PBC_ADDR_CTRL, 8'h27);
		sc <= 1'b1;
		cyc(8);
		outs(5'h1f);
		cyc(30);
		outs(5'h01);
		pins(5'h00);
		cyc(5);
		outs(5'h01);
		ctl(8'h24);
		$display("t_faults done");
	endtask : t_faults
	task automatic t_standby();
		logic [2:0] s;
		for (int e = 0; e < 8; e++) begin
			s = (e == 7) ? 3'h4 : 3'h7;
			ctl({2'b00, e[2:0], s});
			pins(5'h01);
			cyc(4);
			pins(5'h00);
			host_u.rd(PBC_ADDR_CTRL, v);
			`CHK("exit copy", {2'b00, e[2:0], (e == 4 || e == 7) ? e[2:0] : s}, v)
		end
		cyc(2);
		`CHK("en", 1'b1, en)
		$display("t_standby done");
	endtask : t_standby
	task automatic results();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			results();
		end
	end
	initial begin
		{clk, rst_n, ov, uv, oc, sc, pin} = 7'h00;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		cyc(1);
		t_reset();
		host_u.init();
		t_regs();
		t_faults();
		t_standby();
		results();
	end
endmodule : test_pa_boost_control_and_fault
